// [rtl/lcdhp_pkg.sv]
// Constants, field positions and state codes shared by the host port
// Assumes a single core clock; nothing here is tied to a bus
package lcdhp_pkg;
  localparam int DATA_W = 8;
  localparam int AC_W = 7;
  localparam int COM_N = 34;
  localparam logic [5:0] ROWS_17 = 6'h10;
  localparam logic [5:0] ROWS_33 = 6'h20;
  localparam int EXT_DOTS_DEF = 40;
  localparam int FIFO_DEPTH_DEF = 4;
  localparam int FIFO_W = 9;
  // Row period in core clocks; must exceed twice the extension dots
  localparam int ROW_CYCLES_DEF = 128;
  localparam int SYNC_W = 13;
  // Serial start byte: five sync ones, then direction, then select
  localparam logic [4:0] SER_SYNC = 5'h1f;
  localparam int SB_RW = 2;
  localparam int SB_RS = 1;
  // Instruction fields decoded locally
  localparam int IR_DDA_BIT = 7;
  localparam logic [1:0] IR_CGA_TAG = 2'h1;
  localparam logic [2:0] IR_FSET_TAG = 3'h1;
  localparam int IR_DL_BIT = 4;
  localparam logic [5:0] IR_ENTRY_TAG = 6'h01;
  localparam int IR_ID_BIT = 1;
  // Reset values
  localparam logic [AC_W-1:0] RST_AC = 7'h00;
  localparam logic RST_WIDTH8 = 1'b1;
  localparam logic RST_INC = 1'b1;
  typedef enum logic [1:0]
  {
    SER_IDLE = 2'h0,
    SER_START = 2'h1,
    SER_BYTE = 2'h3,
    SER_SKIP = 2'h2
  } lcdhp_ser_e;
endpackage

// [rtl/lcdhp_fifo.sv]
// Shift-register FIFO; the head word and all flags sit in flip-flops
// Assumes both sides run on core_clk
`timescale 1ns/1ps
`default_nettype none
module lcdhp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [DEPTH-1:0] vld_q, vld_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [DEPTH-1:0] sh_v;
  logic [WIDTH-1:0] sh_m [DEPTH];
  logic pop, push;

  assign in_ready = ~vld_q[DEPTH-1];
  assign out_valid = vld_q[0];
  assign out_data = mem_q[0];

  always_comb
  begin
    pop = vld_q[0] & out_ready;
    push = in_valid & ~vld_q[DEPTH-1];
    for (int i = 0; i < DEPTH; i++)
    begin
      if (pop)
      begin
        sh_v[i] = (i + 1 < DEPTH) ? vld_q[(i + 1) % DEPTH] : 1'b0;
        sh_m[i] = mem_q[(i + 1) % DEPTH];
      end
      else
      begin
        sh_v[i] = vld_q[i];
        sh_m[i] = mem_q[i];
      end
    end
    for (int i = 0; i < DEPTH; i++)
    begin
      vld_d[i] = sh_v[i];
      mem_d[i] = sh_m[i];
      if (push && !sh_v[i] && (i == 0 || sh_v[(i + DEPTH - 1) % DEPTH]))
      begin
        vld_d[i] = 1'b1;
        mem_d[i] = in_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vld_q <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else if (clk_en)
    begin
      vld_q <= vld_d;
      mem_q <= mem_d;
    end
  end
endmodule
`default_nettype wire

// [rtl/lcdhp_top.sv]
// Host port, common scan and extension driver outputs of the controller
// Assumes pins are asynchronous to core_clk; core side is synchronous
//
// How it works
// [R1] Strap low serial, high parallel; width instruction
// [R2] Select low: instruction/status; high: data
// [R3] Serial mode: select pin is active-low chip select
// [R4] Bus mode: direction low write, high read
// [R5] Serial data sampled on direction pin
// [R6] Strobe starts bus cycles; serial clock in serial
// [R7] Upper lines bidirectional, top carries busy, serial unused
// [R8] Lines one to three only in 8-bit mode
// [R9] Line zero: LSB in 8-bit, serial out
// [R10] 1/17: rows 1-16, icons 0/17, rest idle
// [R11] 1/33: rows 1-32, icons 0 and 33
// [R12] Unused commons idle; icon pair identical
// [R13] Extension strap high: latch pulse per row
// [R14] Extension strap high: shift clock output
// [R15] Extension data serial, dots beyond own sixty
// [R16] Extension strap high: drive polarity output
// [R17] Extension strap low: outputs high impedance
// [R18] Reset input active low initializes everything
// [R19] Host waits until busy reads zero
// [R20] Status read: busy top, counter below
// [R21] Counter steps after each data access
// [R22] 4-bit: two strobes, high nibble first
// [R23] Drive data lines only while reading
`timescale 1ns/1ps
`default_nettype none
module lcdhp_top #(
  parameter int EXT_DOTS = lcdhp_pkg::EXT_DOTS_DEF,
  parameter int ROW_CYCLES = lcdhp_pkg::ROW_CYCLES_DEF,
  parameter int FIFO_DEPTH = lcdhp_pkg::FIFO_DEPTH_DEF
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic interface_select_strap,
  input wire logic expansion_enable_strap,
  input wire logic register_select,
  input wire logic rw_serial_input_line,
  input wire logic strobe_serial_clock,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic [7:0] data_oe,
  input wire logic core_busy,
  input wire logic [7:0] read_byte,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic cmd_is_data,
  output logic [7:0] cmd_byte,
  output logic [6:0] address_counter,
  output logic bus_width_bit,
  input wire logic duty_select_33,
  input wire logic [EXT_DOTS-1:0] ext_row_bits,
  output logic [lcdhp_pkg::COM_N-1:0] common_row_outputs,
  output logic expansion_latch_pulse,
  output logic expansion_shift_clock,
  output logic expansion_data,
  output logic expansion_polarity,
  output logic expansion_oe
);
  localparam int TW = $clog2(ROW_CYCLES);
  localparam int PW = $clog2(2 * EXT_DOTS + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(ROW_CYCLES - 1);
  localparam logic [PW-1:0] PH_END = PW'(2 * EXT_DOTS);

  function automatic logic [6:0] ac_step(input logic [6:0] ac,
                                         input logic inc);
    return inc ? 7'(ac + 7'h01) : 7'(ac - 7'h01);
  endfunction

  function automatic logic [lcdhp_pkg::COM_N-1:0] com_map(
    input logic [5:0] row, input logic d33);
    logic [5:0] last;
    logic [lcdhp_pkg::COM_N-1:0] v;
    last = d33 ? lcdhp_pkg::ROWS_33 : lcdhp_pkg::ROWS_17;
    v = '0;
    for (int j = 0; j < lcdhp_pkg::COM_N; j++)
    begin
      if (row < last && j == int'(row) + 1)
        v[j] = 1'b1;
      else if (row == last && (j == 0 || j == int'(last) + 1))
        v[j] = 1'b1;
    end
    return v;
  endfunction

  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  logic [lcdhp_pkg::SYNC_W-1:0] s1_q, s2_q;
  logic e_p_q;
  logic ims_s, ext_s, rs_s, rw_s, e_s, e_rise, e_fall;
  logic [7:0] data_s;

  assign {ims_s, ext_s, rs_s, rw_s, e_s, data_s} = s2_q;
  assign e_rise = e_s & ~e_p_q;
  assign e_fall = ~e_s & e_p_q;

  // [R18] Asynchronous active-low reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      e_p_q <= 1'b0;
    end
    else if (clk_en)
    begin
      s1_q <= {interface_select_strap, expansion_enable_strap,
               register_select, rw_serial_input_line,
               strobe_serial_clock, data_in};
      s2_q <= s1_q;
      e_p_q <= e_s;
    end
  end

  // --------------------------------------------------------------
  // Host access: bus and serial
  // --------------------------------------------------------------
  lcdhp_pkg::lcdhp_ser_e st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [6:0] sh_q, sh_d, ac_q, ac_d;
  logic srw_q, srw_d, srs_q, srs_d, nib_q, nib_d;
  logic width8_q, width8_d, inc_q, inc_d, busy_q, busy_d;
  logic [3:0] hi_q, hi_d;
  logic [7:0] rd_byte_q, rd_byte_d, dout_q, dout_d, doe_q, doe_d, nb;
  logic [7:0] wr_byte;
  logic wr_fire, wr_rs, rd_done, rd_rs, fifo_ready;

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    srw_d = srw_q;
    srs_d = srs_q;
    nib_d = nib_q;
    hi_d = hi_q;
    rd_byte_d = rd_byte_q;
    wr_fire = 1'b0;
    wr_rs = 1'b0;
    wr_byte = 8'h00;
    rd_done = 1'b0;
    rd_rs = 1'b0;
    nb = {sh_q, rw_s};
    dout_d = 8'h00;
    doe_d = 8'h00;
    // [R1] Strap chooses the interface
    if (ims_s)
    begin
      st_d = lcdhp_pkg::SER_IDLE;
      // [R4] Read cycle: latch status or data at strobe rise
      if (e_rise && rw_s && (width8_q || !nib_q))
        // [R2] [R20] Select low gives busy over the counter
        rd_byte_d = rs_s ? read_byte : {busy_q, ac_q};
      if (e_fall)
      begin
        if (width8_q)
        begin
          // [R6] Strobe fall completes the cycle
          rd_done = rw_s;
          wr_fire = ~rw_s;
          wr_byte = data_s;
        end
        else
        begin
          // [R22] High nibble first, low nibble completes
          nib_d = ~nib_q;
          if (!nib_q && !rw_s)
            hi_d = data_s[7:4];
          rd_done = nib_q & rw_s;
          wr_fire = nib_q & ~rw_s;
          wr_byte = {hi_q, data_s[7:4]};
        end
        rd_rs = rs_s;
        wr_rs = rs_s;
      end
      // [R23] [R7] [R8] Lines driven only while strobe reads
      if (rw_s && e_s)
      begin
        doe_d = width8_q ? 8'hff : 8'hf0;
        if (width8_q)
          dout_d = rd_byte_q;
        else
          dout_d = nib_q ? {rd_byte_q[3:0], 4'h0} : {rd_byte_q[7:4], 4'h0};
      end
    end
    // [R3] Chip select high aborts and re-arms the frame
    else if (rs_s)
    begin
      st_d = lcdhp_pkg::SER_START;
      cnt_d = 3'h0;
    end
    else
    begin
      if (st_q == lcdhp_pkg::SER_IDLE)
      begin
        st_d = lcdhp_pkg::SER_START;
        cnt_d = 3'h0;
      end
      // [R5] [R6] Serial data sampled on serial clock rise
      else if (e_rise)
      begin
        sh_d = nb[6:0];
        cnt_d = 3'(cnt_q + 3'h1);
        if (cnt_q == 3'h7)
        begin
          unique case (st_q)
            lcdhp_pkg::SER_START:
            begin
              if (nb[7:3] == lcdhp_pkg::SER_SYNC)
              begin
                st_d = lcdhp_pkg::SER_BYTE;
                srw_d = nb[lcdhp_pkg::SB_RW];
                srs_d = nb[lcdhp_pkg::SB_RS];
                rd_byte_d = nb[lcdhp_pkg::SB_RS] ? read_byte
                                                 : {busy_q, ac_q};
              end
              else
                st_d = lcdhp_pkg::SER_SKIP;
            end
            lcdhp_pkg::SER_BYTE:
            begin
              wr_fire = ~srw_q;
              wr_rs = srs_q;
              wr_byte = nb;
              rd_done = srw_q;
              rd_rs = srs_q;
              rd_byte_d = srs_q ? read_byte : {busy_q, ac_q};
            end
            lcdhp_pkg::SER_SKIP:
              st_d = lcdhp_pkg::SER_SKIP;
            lcdhp_pkg::SER_IDLE:
              st_d = lcdhp_pkg::SER_START;
          endcase
        end
      end
      // [R9] Serial output on line zero, MSB first
      if (st_q == lcdhp_pkg::SER_BYTE && srw_q)
      begin
        doe_d = 8'h01;
        dout_d = {7'h00, rd_byte_q[~cnt_q]};
      end
    end
  end

  always_comb
  begin
    ac_d = ac_q;
    inc_d = inc_q;
    width8_d = width8_q;
    // [R21] Counter steps after every data access
    if ((wr_fire && wr_rs) || (rd_done && rd_rs))
      ac_d = ac_step(ac_q, inc_q);
    else if (wr_fire)
    begin
      if (wr_byte[lcdhp_pkg::IR_DDA_BIT])
        ac_d = wr_byte[6:0];
      else if (wr_byte[7:6] == lcdhp_pkg::IR_CGA_TAG)
        ac_d = {1'b0, wr_byte[5:0]};
      // [R1] Width bit taken from the function-set instruction
      else if (wr_byte[7:5] == lcdhp_pkg::IR_FSET_TAG)
        width8_d = wr_byte[lcdhp_pkg::IR_DL_BIT];
      else if (wr_byte[7:2] == lcdhp_pkg::IR_ENTRY_TAG)
        inc_d = wr_byte[lcdhp_pkg::IR_ID_BIT];
    end
    // [R19] A full queue reads as busy so the host waits
    busy_d = core_busy | ~fifo_ready;
  end

  // [R18] Controller state initialised by reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= lcdhp_pkg::SER_IDLE;
      cnt_q <= 3'h0;
      sh_q <= 7'h00;
      srw_q <= 1'b0;
      srs_q <= 1'b0;
      nib_q <= 1'b0;
      hi_q <= 4'h0;
      rd_byte_q <= 8'h00;
      dout_q <= 8'h00;
      doe_q <= 8'h00;
      ac_q <= lcdhp_pkg::RST_AC;
      inc_q <= lcdhp_pkg::RST_INC;
      width8_q <= lcdhp_pkg::RST_WIDTH8;
      busy_q <= 1'b0;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      srw_q <= srw_d;
      srs_q <= srs_d;
      // Width change restarts nibble pairing
      nib_q <= (width8_d != width8_q) ? 1'b0 : nib_d;
      hi_q <= hi_d;
      rd_byte_q <= rd_byte_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
      ac_q <= ac_d;
      inc_q <= inc_d;
      width8_q <= width8_d;
      busy_q <= busy_d;
    end
  end

  // Writes beyond a full queue are dropped; busy warns the host first
  lcdhp_fifo #(.WIDTH(lcdhp_pkg::FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(wr_fire),
    .in_ready(fifo_ready),
    .in_data({wr_rs, wr_byte}),
    .out_valid(cmd_valid),
    .out_ready(cmd_ready),
    .out_data({cmd_is_data, cmd_byte})
  );

  assign data_out = dout_q;
  assign data_oe = doe_q;
  assign address_counter = ac_q;
  assign bus_width_bit = width8_q;

  // --------------------------------------------------------------
  // Common scan and extension driver
  // --------------------------------------------------------------
  logic [TW-1:0] tick_q, tick_d;
  logic [5:0] row_q, row_d;
  logic [PW-1:0] ph_q, ph_d;
  logic [EXT_DOTS-1:0] esh_q, esh_d;
  logic [lcdhp_pkg::COM_N-1:0] com_q, com_d;
  logic duty_q, duty_d, m_q, m_d, lp_q, lp_d, sc_q, sc_d, ed_q, ed_d;
  logic eoe_q, eoe_d, tick, wrap;
  logic pol_q, pol_d;

  always_comb
  begin
    tick = (tick_q == TICK_LAST);
    wrap = tick && (row_q == (duty_q ? lcdhp_pkg::ROWS_33
                                     : lcdhp_pkg::ROWS_17));
    tick_d = tick ? '0 : TW'(tick_q + 1'b1);
    row_d = wrap ? 6'h00 : (tick ? 6'(row_q + 6'h01) : row_q);
    duty_d = wrap ? duty_select_33 : duty_q;
    m_d = wrap ? ~m_q : m_q;
    // [R10] [R11] [R12] Row map, idle commons stay low
    com_d = com_map(row_q, duty_q);
    ph_d = ph_q;
    esh_d = esh_q;
    sc_d = 1'b0;
    ed_d = ed_q;
    if (tick)
    begin
      ph_d = '0;
      esh_d = ext_row_bits;
    end
    // [R14] [R15] Shift clock and dots, MSB first
    else if (ph_q != PH_END)
    begin
      ph_d = PW'(ph_q + 1'b1);
      sc_d = ph_q[0];
      ed_d = esh_q[EXT_DOTS-1];
      if (ph_q[0])
        esh_d = {esh_q[EXT_DOTS-2:0], 1'b0};
    end
    // [R17] Strap low: everything released and quiet
    eoe_d = ext_s;
    // [R16] Polarity flips each frame, gated by the strap
    pol_d = m_d & ext_s;
    // [R13] One latch pulse per row
    lp_d = ext_s & tick;
    if (!ext_s)
    begin
      sc_d = 1'b0;
      ed_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_q <= '0;
      row_q <= 6'h00;
      duty_q <= 1'b0;
      m_q <= 1'b0;
      com_q <= '0;
      ph_q <= PH_END;
      esh_q <= '0;
      sc_q <= 1'b0;
      ed_q <= 1'b0;
      lp_q <= 1'b0;
      eoe_q <= 1'b0;
      pol_q <= 1'b0;
    end
    else if (clk_en)
    begin
      tick_q <= tick_d;
      row_q <= row_d;
      duty_q <= duty_d;
      m_q <= m_d;
      com_q <= com_d;
      ph_q <= ph_d;
      esh_q <= esh_d;
      sc_q <= sc_d;
      ed_q <= ed_d;
      lp_q <= lp_d;
      eoe_q <= eoe_d;
      pol_q <= pol_d;
    end
  end

  assign common_row_outputs = com_q;
  assign expansion_latch_pulse = lp_q;
  assign expansion_shift_clock = sc_q;
  assign expansion_data = ed_q;
  assign expansion_polarity = pol_q;
  assign expansion_oe = eoe_q;

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_bus_rd_start;
    clk_en && ims_s && e_rise && rw_s && width8_q && !rs_s;
  endsequence
  sequence s_row_tick;
    clk_en && tick && ext_s;
  endsequence

  a_oe_reads: assert property ((|doe_q[7:1]) |-> // [R23]
    $past(ims_s && rw_s && e_s)) else $error("bus driven outside read");
  a_oe_width: assert property ((|doe_q[3:1]) |-> $past(width8_q)) // [R8]
    else $error("low lines driven in 4-bit mode");
  a_serial_idle: assert property ((doe_q[0] && !$past(ims_s)) |-> // [R9]
    $past(st_q == lcdhp_pkg::SER_BYTE && srw_q && !rs_s))
    else $error("serial out driven outside read");
  a_status_byte: assert property (s_bus_rd_start |=> // [R20]
    rd_byte_q == {$past(busy_q), $past(ac_q)})
    else $error("status byte wrong");
  a_ac_step: assert property ((clk_en && wr_fire && wr_rs) |=> // [R21]
    ac_q == ac_step($past(ac_q), $past(inc_q)))
    else $error("counter did not step");
  a_nibble_hi: assert property ((clk_en && ims_s && !width8_q // [R22]
    && e_fall && !rw_s && !nib_q) |=> hi_q == $past(data_s[7:4]) ##0 nib_q)
    else $error("high nibble not held");
  a_latch_row: assert property (s_row_tick |=> // [R13]
    lp_q ##1 !lp_q || !clk_en) else $error("latch pulse missing");
  a_ext_off: assert property ((clk_en && !ext_s) |=> // [R17]
    !eoe_q && !lp_q && !sc_q && !ed_q && !expansion_polarity)
    else $error("extension outputs active with strap low");
  a_icon_pair: assert property ($stable(duty_q) |-> // [R12]
    com_q[0] == (duty_q ? com_q[33] : com_q[17]))
    else $error("icon commons differ");
  a_idle_coms: assert property ((!duty_q && $stable(duty_q)) |-> // [R10]
    com_q[33:18] == '0) else $error("unused commons selected");
  a_one_row: assert property ((duty_q && $stable(duty_q) // [R11]
    && !com_q[0]) |-> $onehot0(com_q[32:1]))
    else $error("several rows selected");
endmodule
`default_nettype wire

// [test/lcdhp_host.sv]
// Host processor model for the shared host pins, bus and serial modes
// Assumes the bench calls its tasks; pins move just after core_clk rises
`timescale 1ns/1ps
`default_nettype none
module lcdhp_host (
  input wire logic core_clk,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe,
  output logic register_select,
  output logic rw_serial_input_line,
  output logic strobe_serial_clock,
  output logic [7:0] data_in
);
  logic [7:0] drv_q = 8'h00;
  logic drv_on = 1'b0;
  // ----------------------------------------------------------------
  // Data line levels
  // ----------------------------------------------------------------
  // Released lines show the inverse of the last value, never a copy
  assign data_in = (data_oe & data_out) |
                   (~data_oe & (drv_on ? drv_q : ~drv_q));
  initial
  begin
    register_select = 1'b1;
    rw_serial_input_line = 1'b0;
    strobe_serial_clock = 1'b0;
  end
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic pulse(input logic rs, input logic rw, input logic [7:0] w,
    output logic [7:0] r, output logic [7:0] oe);
    // select and direction held across the strobe
    register_select <= rs;
    rw_serial_input_line <= rw;
    drv_q <= w;
    drv_on <= ~rw;
    wait_n(4);
    strobe_serial_clock <= 1'b1;
    wait_n(7);
    r = data_in;
    oe = data_oe;
    strobe_serial_clock <= 1'b0;
    wait_n(6);
    drv_on <= 1'b0;
    wait_n(2);
  endtask
  task automatic xfer(input logic rs, input logic rw, input logic wide,
    input logic [7:0] w, output logic [7:0] r, output logic [7:0] oe);
    logic [7:0] h;
    logic [7:0] l;
    logic [7:0] o2;
    if (wide)
      pulse(rs, rw, w, r, oe);
    else
    begin
      // high nibble first on the upper lines
      pulse(rs, rw, {w[7:4], 4'h0}, h, oe);
      pulse(rs, rw, {w[3:0], 4'h0}, l, o2);
      r = {h[7:4], l[7:4]};
    end
  endtask
  task automatic write(input logic rs, input logic wide, input logic [7:0] w,
    output logic ok);
    logic [7:0] st;
    logic [7:0] oe;
    int k;
    st = 8'hff;
    k = 0;
    while (st[7] !== 1'b0 && k < 40)
    begin
      xfer(1'b0, 1'b1, wide, 8'h00, st, oe);
      k++;
    end
    ok = (st[7] === 1'b0);
    if (ok)
      xfer(rs, 1'b0, wide, w, st, oe);
  endtask
  // ----------------------------------------------------------------
  // Serial frame: start byte then one byte, clock idles low
  // ----------------------------------------------------------------
  task automatic frame(input logic cs_n, input logic [7:0] sb,
    input logic [7:0] b, output logic [7:0] r, output logic oe0);
    logic [15:0] bits;
    bits = {sb, b};
    oe0 = 1'b0;
    register_select <= cs_n;
    wait_n(4);
    for (int i = 15; i >= 0; i--)
    begin
      // data on direction pin, clock on strobe
      rw_serial_input_line <= bits[i];
      wait_n(4);
      if (i < 8)
        r[i] = data_in[0];
      if (i == 4)
        oe0 = data_oe[0];
      strobe_serial_clock <= 1'b1;
      wait_n(4);
      strobe_serial_clock <= 1'b0;
    end
    wait_n(4);
    register_select <= 1'b1;
    wait_n(4);
  endtask
endmodule
`default_nettype wire

// [test/tb_lcdhp_top.sv]
// Self-checking bench for the host port, common scan and extension pins
// Assumes lcdhp_host holds the host side; core side is driven here
`timescale 1ns/1ps
`default_nettype none
module tb_lcdhp_top;
  logic core_clk, rst_n, clk_en, sel_strap, exp_strap, core_busy;
  logic cmd_ready, d33, rs_pin, rw_pin, stb_pin, cmd_valid, cmd_is_data;
  logic bus_width_bit, lp, sc, xd, pol, xoe;
  logic [7:0] din, dout, doe, read_byte, cmd_byte;
  logic [6:0] address_counter;
  logic [3:0] row_bits;
  logic [33:0] coms;
  int bad_count = 0;
  int n_checks = 0;
  lcdhp_host host_u (.core_clk(core_clk), .data_out(dout), .data_oe(doe),
    .register_select(rs_pin), .rw_serial_input_line(rw_pin),
    .strobe_serial_clock(stb_pin), .data_in(din));
  lcdhp_top #(.EXT_DOTS(4), .ROW_CYCLES(16), .FIFO_DEPTH(4)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .interface_select_strap(sel_strap), .expansion_enable_strap(exp_strap),
    .register_select(rs_pin), .rw_serial_input_line(rw_pin),
    .strobe_serial_clock(stb_pin), .data_in(din), .data_out(dout),
    .data_oe(doe), .core_busy(core_busy), .read_byte(read_byte),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_is_data(cmd_is_data),
    .cmd_byte(cmd_byte), .address_counter(address_counter),
    .bus_width_bit(bus_width_bit), .duty_select_33(d33),
    .ext_row_bits(row_bits), .common_row_outputs(coms),
    .expansion_latch_pulse(lp), .expansion_shift_clock(sc),
    .expansion_data(xd), .expansion_polarity(pol), .expansion_oe(xoe));
  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      bad_count++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Head is held until checked, then popped with one ready cycle
  task automatic expect_cmd(input logic isd, input logic [7:0] b);
    int k;
    k = 0;
    while (cmd_valid !== 1'b1 && k < 40)
    begin
      @(posedge core_clk);
      k++;
    end
    if (cmd_valid !== 1'b1)
    begin
      bad_count++;
      conclude();
    end
    check(cmd_is_data, isd);
    check(cmd_byte, b);
    cmd_ready <= 1'b1;
    @(posedge core_clk);
    cmd_ready <= 1'b0;
    tick(3);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_bus8();
    logic [7:0] r, oe;
    logic ok;
    check(bus_width_bit, 1'b1);
    check(address_counter, 7'h00);
    host_u.write(1'b0, 1'b1, 8'h85, ok);
    check(ok, 1'b1);
    expect_cmd(1'b0, 8'h85);
    host_u.write(1'b1, 1'b1, 8'h41, ok);
    expect_cmd(1'b1, 8'h41);
    check(address_counter, 7'h06);
    read_byte <= 8'h5a;
    host_u.xfer(1'b1, 1'b1, 1'b1, 8'h00, r, oe);
    check(r, 8'h5a);
    check(oe, 8'hff);
    tick(6);
    host_u.xfer(1'b0, 1'b1, 1'b1, 8'h00, r, oe);
    check(r, 8'h07);
    check(doe, 8'h00);
    host_u.write(1'b0, 1'b1, 8'h04, ok);
    expect_cmd(1'b0, 8'h04);
    host_u.write(1'b1, 1'b1, 8'h22, ok);
    expect_cmd(1'b1, 8'h22);
    check(address_counter, 7'h06);
    $display("test bus8 done");
  endtask
  task automatic t_fifo();
    logic [7:0] r, oe;
    logic ok;
    for (int i = 0; i < 4; i++)
    begin
      host_u.write(1'b1, 1'b1, 8'h10 + 8'(i), ok);
      check(ok, 1'b1);
    end
    host_u.xfer(1'b0, 1'b1, 1'b1, 8'h00, r, oe);
    check(r[7], 1'b1);
    for (int i = 0; i < 4; i++)
      expect_cmd(1'b1, 8'h10 + 8'(i));
    check(cmd_valid, 1'b0);
    core_busy <= 1'b1;
    host_u.xfer(1'b0, 1'b1, 1'b1, 8'h00, r, oe);
    check(r[7], 1'b1);
    core_busy <= 1'b0;
    $display("test fifo done");
  endtask
  task automatic t_bus4();
    logic [7:0] r, oe;
    logic ok;
    host_u.write(1'b0, 1'b1, 8'h20, ok);
    expect_cmd(1'b0, 8'h20);
    check(bus_width_bit, 1'b0);
    host_u.write(1'b0, 1'b0, 8'h83, ok);
    expect_cmd(1'b0, 8'h83);
    host_u.xfer(1'b0, 1'b1, 1'b0, 8'h00, r, oe);
    check(r, 8'h03);
    check(oe, 8'hf0);
    host_u.write(1'b0, 1'b0, 8'h30, ok);
    expect_cmd(1'b0, 8'h30);
    check(bus_width_bit, 1'b1);
    $display("test bus4 done");
  endtask
  task automatic t_serial();
    logic [7:0] r;
    logic o;
    sel_strap <= 1'b0;
    tick(6);
    host_u.frame(1'b0, 8'hfa, 8'hc3, r, o);
    expect_cmd(1'b1, 8'hc3);
    host_u.frame(1'b1, 8'hfa, 8'h3c, r, o);
    host_u.frame(1'b0, 8'h7a, 8'h3c, r, o);
    tick(20);
    check(cmd_valid, 1'b0);
    read_byte <= 8'ha6;
    host_u.frame(1'b0, 8'hfe, 8'h00, r, o);
    check(r, 8'ha6);
    check(o, 1'b1);
    sel_strap <= 1'b1;
    tick(6);
    $display("test serial done");
  endtask
  task automatic t_ext();
    logic [3:0] got;
    logic prev;
    int n, k;
    tick(20);
    check(xoe, 1'b0);
    check(pol, 1'b0);
    exp_strap <= 1'b1;
    k = 0;
    while (lp !== 1'b1 && k < 100)
    begin
      @(posedge core_clk);
      k++;
    end
    check(k < 100, 1'b1);
    check(xoe, 1'b1);
    got = 4'h0;
    n = 0;
    prev = sc;
    repeat (14)
    begin
      @(posedge core_clk);
      if (sc === 1'b1 && prev === 1'b0)
      begin
        got = {got[2:0], xd};
        n++;
      end
      prev = sc;
    end
    check(n, 4);
    check(got, 4'hb);
    $display("test ext done");
  endtask
  task automatic watch(input int n, input int top, output logic [33:0] acc,
    output int bad_pair, output logic pol_chg);
    logic p0;
    acc = '0;
    bad_pair = 0;
    pol_chg = 1'b0;
    p0 = pol;
    repeat (n)
    begin
      @(posedge core_clk);
      acc |= coms;
      if (coms[0] !== coms[top])
        bad_pair++;
      if (pol !== p0)
        pol_chg = 1'b1;
    end
  endtask
  task automatic t_duty();
    logic [33:0] acc;
    logic pc;
    int bp;
    tick(600);
    watch(17 * 16, 17, acc, bp, pc);
    check(acc, 34'h0_0003_ffff);
    check(bp, 0);
    d33 <= 1'b1;
    tick(17 * 16 + 20);
    watch(33 * 16, 33, acc, bp, pc);
    check(acc, 34'h3_ffff_ffff);
    check(bp, 0);
    check(pc, 1'b1);
    $display("test duty done");
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    sel_strap = 1'b1;
    exp_strap = 1'b0;
    core_busy = 1'b0;
    cmd_ready = 1'b0;
    d33 = 1'b0;
    read_byte = 8'h00;
    row_bits = 4'hb;
    tick(8);
    rst_n <= 1'b1;
    tick(4);
    t_bus8();
    t_fifo();
    t_bus4();
    t_serial();
    t_ext();
    t_duty();
    conclude();
  end
endmodule
`default_nettype wire
